// ---- logic/psbp_host.sv ----
// Host end: APB-controlled external processor driving the byte port
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module psbp_host (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Link
   psbp_if.host link
);
   psbp_pkg::psbp_host_st_t st_q, st_d;
   logic [7:0] wdat_q, wdat_d, rdat_q, rdat_d;
   logic is_rd_q, is_rd_d;
   logic [3:0] cnt_q, cnt_d;
   logic [1:0] sts_q, sts_d, msk_q, msk_d;
   logic [31:0] prdata_q, prdata_d;
   logic rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
   logic cs_q, cs_d, rs_q, rs_d, ws_q, ws_d, oe_q, oe_d;
   logic acc, wr, fin;

   always_comb begin
      acc = psel && penable && !rdy_q;
      wr = acc && pwrite;
      st_d = st_q;
      cnt_d = cnt_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      is_rd_d = is_rd_q;
      fin = 1'b0;
      cs_d = 1'b1;
      rs_d = 1'b1;
      ws_d = 1'b1;
      oe_d = 1'b0;
      if (wr && paddr == psbp_pkg::ADDR_LATCH) begin
         wdat_d = pwdata[7:0];
      end
      case (st_q)
         psbp_pkg::PSBP_IDLE: begin
            if (wr && paddr == psbp_pkg::ADDR_CMD && pwdata[psbp_pkg::CMD_GO_BIT]) begin
               is_rd_d = pwdata[psbp_pkg::CMD_RD_BIT];
               st_d = psbp_pkg::PSBP_SETUP;
            end
         end
         psbp_pkg::PSBP_SETUP: begin
            // Data drive and strobes fall on the same edge, no clock shared with device
            oe_d = !is_rd_q;
            cs_d = 1'b0;
            rs_d = !is_rd_q;
            ws_d = is_rd_q;
            cnt_d = psbp_pkg::STROBE_CYCLES;
            st_d = psbp_pkg::PSBP_STROBE;
         end
         psbp_pkg::PSBP_STROBE: begin
            oe_d = !is_rd_q;
            cs_d = 1'b0;
            rs_d = !is_rd_q;
            ws_d = is_rd_q;
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               if (is_rd_q) begin
                  rdat_d = link.bus_data;
               end
               cs_d = 1'b1;
               rs_d = 1'b1;
               ws_d = 1'b1;
               oe_d = !is_rd_q;
               cnt_d = psbp_pkg::GAP_CYCLES;
               st_d = psbp_pkg::PSBP_GAP;
            end
         end
         psbp_pkg::PSBP_GAP: begin
            // Gap lets the device see strobes high before the next access
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               fin = 1'b1;
               st_d = psbp_pkg::PSBP_IDLE;
            end
         end
         default: st_d = psbp_pkg::PSBP_IDLE;
      endcase
      sts_d = sts_q;
      if (wr && paddr == psbp_pkg::ADDR_STATUS) begin
         sts_d = sts_q & ~pwdata[1:0];
      end
      if (fin) begin
         sts_d[is_rd_q ? psbp_pkg::ST_RD_BIT : psbp_pkg::ST_WR_BIT] = 1'b1;
      end
      msk_d = (wr && paddr == psbp_pkg::ADDR_MASK) ? pwdata[1:0] : msk_q;
      irq_d = |(sts_d & msk_d);
      rdy_d = acc;
      err_d = 1'b0;
      prdata_d = psbp_pkg::ZERO_WORD;
      if (acc && !pwrite) begin
         case (paddr)
            psbp_pkg::ADDR_CTRL: prdata_d = {30'h0, st_q};
            psbp_pkg::ADDR_LATCH: prdata_d = {24'h0, wdat_q};
            psbp_pkg::ADDR_STATUS: prdata_d = {30'h0, sts_q};
            psbp_pkg::ADDR_MASK: prdata_d = {30'h0, msk_q};
            psbp_pkg::ADDR_CMD: prdata_d = {31'h0, st_q != psbp_pkg::PSBP_IDLE};
            psbp_pkg::ADDR_RDATA: prdata_d = {24'h0, rdat_q};
            default: err_d = 1'b1;
         endcase
      end else if (acc) begin
         err_d = !(paddr == psbp_pkg::ADDR_LATCH || paddr == psbp_pkg::ADDR_STATUS
            || paddr == psbp_pkg::ADDR_MASK || paddr == psbp_pkg::ADDR_CMD);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= psbp_pkg::PSBP_IDLE;
         cnt_q <= 4'h0;
         wdat_q <= 8'h00;
         rdat_q <= 8'h00;
         is_rd_q <= 1'b0;
         sts_q <= 2'h0;
         msk_q <= 2'h0;
         irq_q <= 1'b0;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         cs_q <= 1'b1;
         rs_q <= 1'b1;
         ws_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wdat_q <= wdat_d;
         rdat_q <= rdat_d;
         is_rd_q <= is_rd_d;
         sts_q <= sts_d;
         msk_q <= msk_d;
         irq_q <= irq_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
         prdata_q <= prdata_d;
         cs_q <= cs_d;
         rs_q <= rs_d;
         ws_q <= ws_d;
         oe_q <= oe_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = rdy_q;
   assign pslverr = err_q;
   assign irq = irq_q;
   assign link.chip_select_n = cs_q;
   assign link.read_strobe_n = rs_q;
   assign link.write_strobe_n = ws_q;
   assign link.host_data_o = wdat_q;
   assign link.host_data_oe = oe_q;
endmodule

// ---- logic/psbp_pkg.sv ----
// Package: constants shared by both ends of the parallel slave byte port
package psbp_pkg;
   localparam int DATA_W = 8;
   localparam int CTRL_W = 3;
   // Control pin bit positions
   localparam int CTRL_READ_BIT = 0;
   localparam int CTRL_WRITE_BIT = 1;
   localparam int CTRL_CS_BIT = 2;
   // Register byte addresses, host-side APB map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LATCH = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0C;
   localparam logic [7:0] ADDR_CMD = 8'h10;
   localparam logic [7:0] ADDR_RDATA = 8'h14;
   // Control register fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_DIR_LSB = 1;
   localparam int CTRL_CFG_LSB = 4;
   localparam logic [2:0] DIR_ALL_INPUT = 3'h7;
   localparam logic [2:0] CFG_DIGITAL = 3'h7;
   // Status and mask bits
   localparam int ST_WR_BIT = 0;
   localparam int ST_RD_BIT = 1;
   localparam int ST_W = 2;
   // Host command bits
   localparam int CMD_GO_BIT = 0;
   localparam int CMD_RD_BIT = 1;
   // Host strobe timing in ref_clk cycles
   localparam logic [3:0] STROBE_CYCLES = 4'h6;
   localparam logic [3:0] GAP_CYCLES = 4'h3;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {
      PSBP_IDLE = 2'b00,
      PSBP_SETUP = 2'b01,
      PSBP_STROBE = 2'b10,
      PSBP_GAP = 2'b11
   } psbp_host_st_t;
endpackage

// ---- logic/psbp_if.sv ----
// Interface: byte bus and active-low strobes between the two ends
`timescale 1ns/1ps
interface psbp_if;
   logic [7:0] host_data_o;
   logic host_data_oe;
   logic [7:0] dev_data_o;
   logic dev_data_oe;
   logic read_strobe_n;
   logic write_strobe_n;
   logic chip_select_n;
   logic [7:0] bus_data;
   assign bus_data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hFF);
   modport device (
      input bus_data, read_strobe_n, write_strobe_n, chip_select_n,
      output dev_data_o, dev_data_oe
   );
   modport host (
      input bus_data,
      output host_data_o, host_data_oe, read_strobe_n, write_strobe_n, chip_select_n
   );
endinterface

// ---- logic/psbp_device.sv ----
// Device end: port latch, strobe qualification and interrupt flag
`timescale 1ns/1ps
module psbp_device (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Link
   psbp_if.device link,
   // Firmware side
   input wire logic parallel_port_enable,
   input wire logic [2:0] port_e_direction,
   input wire logic [2:0] analog_pin_config,
   input wire logic fw_wr,
   input wire logic [7:0] fw_wdata,
   input wire logic flag_clr,
   output logic [7:0] port_d_data_latch,
   output logic parallel_port_irq_flag,
   output logic port_ready,
   output logic ttl_buffer_sel
);
   logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d;
   logic [7:0] latch_q, latch_d;
   logic wr_act_q, wr_act_d, rd_act_q, rd_act_d;
   logic flag_q, flag_d, oe_q, oe_d, rdy_q, rdy_d, ttl_q, ttl_d;
   logic [7:0] dout_q, dout_d;
   logic wr_lo, rd_lo, done;

   always_comb begin
      // Only the second stage is observed, first stage feeds it alone
      sync1_d = {link.chip_select_n, link.write_strobe_n, link.read_strobe_n};
      sync2_d = sync1_q;
      rdy_d = parallel_port_enable && (port_e_direction == psbp_pkg::DIR_ALL_INPUT)
         && (analog_pin_config == psbp_pkg::CFG_DIGITAL);
      ttl_d = parallel_port_enable;
      wr_lo = rdy_q && !sync2_q[psbp_pkg::CTRL_CS_BIT] && !sync2_q[psbp_pkg::CTRL_WRITE_BIT];
      rd_lo = rdy_q && !sync2_q[psbp_pkg::CTRL_CS_BIT] && !sync2_q[psbp_pkg::CTRL_READ_BIT];
      wr_act_d = wr_lo;
      rd_act_d = rd_lo;
      latch_d = latch_q;
      if (fw_wr) begin
         latch_d = fw_wdata;
      end
      // External write wins over a firmware write in the same cycle
      if (wr_lo && !wr_act_q) begin
         latch_d = link.bus_data;
      end
      oe_d = rd_lo;
      dout_d = rd_lo ? latch_q : dout_q;
      done = (wr_act_q && !wr_lo) || (rd_act_q && !rd_lo);
      flag_d = done ? 1'b1 : (flag_clr ? 1'b0 : flag_q);
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 3'h7;
         sync2_q <= 3'h7;
         latch_q <= 8'h00;
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
         flag_q <= 1'b0;
         oe_q <= 1'b0;
         dout_q <= 8'h00;
         rdy_q <= 1'b0;
         ttl_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         latch_q <= latch_d;
         wr_act_q <= wr_act_d;
         rd_act_q <= rd_act_d;
         flag_q <= flag_d;
         oe_q <= oe_d;
         dout_q <= dout_d;
         rdy_q <= rdy_d;
         ttl_q <= ttl_d;
      end
   end

   assign link.dev_data_o = dout_q;
   assign link.dev_data_oe = oe_q;
   assign port_d_data_latch = latch_q;
   assign parallel_port_irq_flag = flag_q;
   assign port_ready = rdy_q;
   assign ttl_buffer_sel = ttl_q;
endmodule

// ---- sim/psbp_chk.sv ----
// Checker: link timing between host and device ends
`timescale 1ns/1ps
module psbp_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Link
   input wire logic [7:0] host_data_o,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chip_select_n
);
   logic rd_go;
   logic wr_go;
   assign rd_go = !chip_select_n && !read_strobe_n;
   assign wr_go = !chip_select_n && !write_strobe_n;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_rd_start;
      $rose(rd_go);
   endsequence
   sequence s_wr_start;
      $rose(wr_go);
   endsequence
   a_read_drive: assert property (s_rd_start |-> ##[1:4] dev_data_oe)
      else $error("device did not drive read data");
   a_drive_cause: assert property ($rose(dev_data_oe) |-> rd_go)
      else $error("device drove bus without read");
   a_drive_release: assert property ($rose(read_strobe_n) |-> ##[1:4] !dev_data_oe)
      else $error("device kept driving after read");
   a_write_hold: assert property (s_wr_start |-> wr_go [*6])
      else $error("write strobe too short");
   a_wdata_stable: assert property (wr_go && $past(wr_go) |-> host_data_oe && $stable(host_data_o))
      else $error("write data moved under strobe");
   a_one_strobe: assert property (!(!read_strobe_n && !write_strobe_n))
      else $error("both strobes low");
   a_strobe_select: assert property (!read_strobe_n || !write_strobe_n |-> !chip_select_n)
      else $error("strobe without chip select");
   a_gap_min: assert property ($rose(chip_select_n) |-> chip_select_n [*3])
      else $error("gap between accesses too short");
endmodule

// ---- sim/tb.sv ----
// Testbench: host and device ends joined over the byte port
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, irq, err;
   logic parallel_port_enable = 1'b0, fw_wr = 1'b0, flag_clr = 1'b0;
   logic [2:0] port_e_direction = 3'h0, analog_pin_config = 3'h0;
   logic [7:0] fw_wdata = 8'h00, port_d_data_latch, b;
   logic parallel_port_irq_flag, port_ready, ttl_buffer_sel;
   int fail_count = 0, n_tests = 0, seed = 65, cyc = 0, k;
   psbp_if i_psbp_if ();
   psbp_host i_psbp_host (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq, .link(i_psbp_if.host));
   psbp_device i_psbp_device (.ref_clk, .arst_n, .link(i_psbp_if.device),
      .parallel_port_enable, .port_e_direction, .analog_pin_config, .fw_wr, .fw_wdata,
      .flag_clr, .port_d_data_latch, .parallel_port_irq_flag, .port_ready, .ttl_buffer_sel);
   psbp_chk i_psbp_chk (.ref_clk, .arst_n, .host_data_o(i_psbp_if.host_data_o),
      .host_data_oe(i_psbp_if.host_data_oe), .dev_data_oe(i_psbp_if.dev_data_oe),
      .read_strobe_n(i_psbp_if.read_strobe_n), .write_strobe_n(i_psbp_if.write_strobe_n),
      .chip_select_n(i_psbp_if.chip_select_n));
   always #4 ref_clk = ~ref_clk;
   task end_sim;
      $display("Checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Hang guard: counts as a mismatch
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         end_sim();
      end
   end
   function automatic logic [31:0] st(logic r, logic w);
      return {30'h0, r, w};
   endfunction
   task chk(string name, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", name, exp, got);
      end
   endtask
   // Starts just after an edge, ends one edge after release
   task apb(logic w, logic [7:0] a, logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         fail_count++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task xfer(logic [31:0] cmd);
      int i;
      apb(1'b1, psbp_pkg::ADDR_CMD, cmd);
      for (i = 0; i < 40; i++) begin
         apb(1'b0, psbp_pkg::ADDR_CMD, 32'h0);
         if (rd[0] === 1'b0)
            break;
      end
      if (i >= 40) begin
         fail_count++;
         end_sim();
      end
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, psbp_pkg::ADDR_STATUS, 32'h0);
      chk("status", st(0, 0), rd);
      chk("ttl", 0, ttl_buffer_sel);
      apb(1'b1, 8'h20, 32'h0);
      chk("unmapped", 1, err);
      apb(1'b1, psbp_pkg::ADDR_CTRL, 32'h0);
      chk("ro", 1, err);
      // Enabled but one control pin left as output: no capture
      parallel_port_enable <= 1'b1;
      port_e_direction <= 3'h6;
      analog_pin_config <= 3'h7;
      apb(1'b1, psbp_pkg::ADDR_LATCH, 32'hA5);
      xfer(32'h1);
      chk("ttl", 1, ttl_buffer_sel);
      chk("ready", 0, port_ready);
      chk("latch", 8'h00, port_d_data_latch);
      port_e_direction <= 3'h7;
      apb(1'b1, psbp_pkg::ADDR_STATUS, 32'h3);
      chk("ready", 1, port_ready);
      apb(1'b1, psbp_pkg::ADDR_MASK, 32'h3);
      apb(1'b0, psbp_pkg::ADDR_MASK, 32'h0);
      chk("mask", 32'h3, rd);
      for (k = 0; k < 10; k++) begin
         b = k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($random(seed));
         apb(1'b1, psbp_pkg::ADDR_LATCH, {24'h0, b});
         xfer(32'h1);
         chk("latch", b, port_d_data_latch);
         chk("flag", 1, parallel_port_irq_flag);
         chk("irq", 1, irq);
         flag_clr <= 1'b1;
         @(posedge ref_clk);
         flag_clr <= 1'b0;
         apb(1'b1, psbp_pkg::ADDR_STATUS, 32'h1);
         chk("flag", 0, parallel_port_irq_flag);
         b = k == 1 ? 8'h00 : ~b ^ 8'($random(seed));
         fw_wr <= 1'b1;
         fw_wdata <= b;
         @(posedge ref_clk);
         fw_wr <= 1'b0;
         xfer(32'h3);
         apb(1'b0, psbp_pkg::ADDR_RDATA, 32'h0);
         chk("rdata", b, rd);
         chk("flag", 1, parallel_port_irq_flag);
         // Clear so the next write proves it sets the flag again
         flag_clr <= 1'b1;
         @(posedge ref_clk);
         flag_clr <= 1'b0;
         apb(1'b0, psbp_pkg::ADDR_STATUS, 32'h0);
         chk("status", st(1, 0), rd);
         apb(1'b1, psbp_pkg::ADDR_STATUS, 32'h3);
      end
      // Masked event sets status but leaves irq low
      apb(1'b1, psbp_pkg::ADDR_MASK, 32'h0);
      apb(1'b1, psbp_pkg::ADDR_LATCH, 32'h3C);
      xfer(32'h1);
      chk("latch", 8'h3C, port_d_data_latch);
      chk("irq", 0, irq);
      apb(1'b0, psbp_pkg::ADDR_STATUS, 32'h0);
      chk("status", st(0, 1), rd);
      // Control pins left analog: strobes must not qualify
      analog_pin_config <= 3'h3;
      apb(1'b1, psbp_pkg::ADDR_LATCH, 32'h5A);
      xfer(32'h1);
      chk("ready", 0, port_ready);
      chk("latch", 8'h3C, port_d_data_latch);
      end_sim();
   end
endmodule
